// >>> pkg/soft_ramp_regs.svh
`ifndef SOFT_RAMP_REGS_SVH
`define SOFT_RAMP_REGS_SVH

// clock and reference update rate
`define SRS_CLK_HZ        10000000
`define SRS_UPDATE_HZ     10000
`define SRS_TICK_CYCLES   (`SRS_CLK_HZ / `SRS_UPDATE_HZ)
`define SRS_TICK_CNT_W    10

// reference and duty code layout
`define SRS_REF_W         12
`define SRS_FRAC_W        8
`define SRS_ACC_W         20
`define SRS_ACC_LSB       20'h00100
`define SRS_REF_MAX       12'hfff
`define SRS_DUTY_MAX      12'hfff
`define SRS_SCALE_SHIFT   7

// counter and gain widths, reset values
`define SRS_TIME_W        16
`define SRS_GAIN_W        16
`define SRS_ACC_RESET     20'h00000
`define SRS_GAIN_RESET    16'h0000

`endif

// >>> pkg/soft_ramp_pkg.sv
package soft_ramp_pkg;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_ON_WAIT  = 3'b001,
      ST_RAMP_UP  = 3'b010,
      ST_REGULATE = 3'b011,
      ST_OFF_WAIT = 3'b100,
      ST_RAMP_DN  = 3'b101
   } rail_state_t;

   typedef enum logic [1:0] {
      MODE_RAMP   = 2'b00,
      MODE_NORMAL = 2'b01,
      MODE_LIGHT  = 2'b10
   } op_mode_t;

endpackage

// >>> design/ramp_tick.sv
`timescale 1ns/10ps
`include "soft_ramp_regs.svh"

module ramp_tick (
   // clock and reset
   input  wire logic clock,
   input  wire logic rst,
   // restart the period so a sequence starts on a whole period
   input  wire logic restart,
   output logic      tick
);

   logic [`SRS_TICK_CNT_W-1:0] count_r;
   wire                        wrap = (count_r == `SRS_TICK_CNT_W'(`SRS_TICK_CYCLES - 1));

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_r <= '0;
         tick    <= 1'b0;
      end else if (restart) begin
         count_r <= '0;
         tick    <= 1'b0;
      end else begin
         count_r <= wrap ? '0 : count_r + `SRS_TICK_CNT_W'(1);
         tick    <= wrap;
      end
   end

endmodule

// >>> design/prebias_duty.sv
`timescale 1ns/10ps
`include "soft_ramp_regs.svh"

module prebias_duty (
   // clock and reset
   input  wire logic                           clock,
   input  wire logic                           rst,
   // operands
   input  wire logic        [`SRS_REF_W-1:0]   refCode,
   input  wire logic        [`SRS_REF_W-1:0]   vinCode,
   input  wire logic        [7:0]              scale,
   input  wire logic signed [`SRS_REF_W-1:0]   offset,
   // duty estimate, 4096 = full period
   output logic             [`SRS_REF_W-1:0]   duty
);

   // nominal duty is vout over vin; a dead input reads as full duty
   wire        [23:0] numer   = {refCode, 12'h000};
   wire        [23:0] rawDuty = (vinCode == '0) ? 24'hffffff : numer / {12'h000, vinCode};
   wire        [31:0] scaled  = rawDuty * {24'h000000, scale};
   wire signed [26:0] shifted = $signed({2'b00, scaled[31:`SRS_SCALE_SHIFT]});
   wire signed [26:0] trimmed = shifted + 27'(offset);
   wire        [11:0] clipped = (trimmed < 0) ? 12'h000 :
                                (trimmed > 27'sh0000fff) ? `SRS_DUTY_MAX : trimmed[11:0];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) duty <= '0;
      else     duty <= clipped;
   end

endmodule

// >>> design/soft_ramp_sequencer.sv
`timescale 1ns/10ps
`include "soft_ramp_regs.svh"

module soft_ramp_sequencer (
   // clock and reset
   input  wire logic                           clock,
   input  wire logic                           rst,
   // start and stop requests
   input  wire logic                           controlInputPin,
   input  wire logic                           pinControlEnable,
   input  wire logic                           cmdOn,
   input  wire logic                           cmdControlEnable,
   // sequencing configuration, times in 100 us update periods
   input  wire logic        [`SRS_TIME_W-1:0]  turnOnDelay,
   input  wire logic        [`SRS_TIME_W-1:0]  riseTime,
   input  wire logic        [`SRS_TIME_W-1:0]  turnOffDelay,
   input  wire logic        [`SRS_TIME_W-1:0]  fallTime,
   input  wire logic        [`SRS_REF_W-1:0]   targetVout,
   input  wire logic                           soleSource,
   input  wire logic        [`SRS_REF_W-1:0]   minPulse,
   input  wire logic        [7:0]              prebiasScale,
   input  wire logic signed [`SRS_REF_W-1:0]   prebiasOffset,
   // loop gain banks
   input  wire logic        [`SRS_GAIN_W-1:0]  gainRamp,
   input  wire logic        [`SRS_GAIN_W-1:0]  gainNormal,
   input  wire logic        [`SRS_GAIN_W-1:0]  gainLight,
   input  wire logic                           lightLoad,
   // sensed rail
   input  wire logic        [`SRS_REF_W-1:0]   voutSense,
   input  wire logic        [`SRS_REF_W-1:0]   vinSense,
   input  wire logic signed [7:0]              errorAdc,
   input  wire logic                           errorAdcSat,
   // power stage and compensator controls
   output logic             [`SRS_REF_W-1:0]   refDac,
   output logic                                pwmOutput,
   output logic                                syncRectifierEnable,
   output logic             [`SRS_GAIN_W-1:0]  loopGain,
   output soft_ramp_pkg::op_mode_t             opMode,
   // status
   output soft_ramp_pkg::rail_state_t          railState,
   output logic                                regulated
);

   soft_ramp_pkg::rail_state_t state_r, state_nxt;
   soft_ramp_pkg::op_mode_t    mode_nxt;
   logic [`SRS_ACC_W-1:0]      acc_r, acc_nxt;
   logic [`SRS_ACC_W-1:0]      stepDn_r, stepDn_nxt;
   logic [`SRS_TIME_W-1:0]     cnt_r, cnt_nxt;
   logic [`SRS_REF_W-1:0]      prebias_r, prebias_nxt;
   logic                       pwm_nxt, sr_nxt;
   logic                       tickRestart;
   logic                       tick;
   logic [`SRS_REF_W-1:0]      duty;
   logic                       pinMeta_r, pinSync_r;

   // control pin is asynchronous to the clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pinMeta_r <= 1'b0;
         pinSync_r <= 1'b0;
      end else begin
         pinMeta_r <= controlInputPin;
         pinSync_r <= pinMeta_r;
      end
   end

   wire runReq = (pinControlEnable & pinSync_r) | (cmdControlEnable & cmdOn);

   ramp_tick u_tick (
      .clock   (clock),
      .rst     (rst),
      .restart (tickRestart),
      .tick    (tick)
   );

   prebias_duty u_duty (
      .clock   (clock),
      .rst     (rst),
      .refCode (acc_r[`SRS_ACC_W-1:`SRS_FRAC_W]),
      .vinCode (vinSense),
      .scale   (prebiasScale),
      .offset  (prebiasOffset),
      .duty    (duty)
   );

   // fractional accumulator keeps the ramp from drifting off the target time
   wire [`SRS_TIME_W-1:0] riseDiv  = (riseTime == '0) ? `SRS_TIME_W'(1) : riseTime;
   wire [`SRS_TIME_W-1:0] fallDiv  = (fallTime == '0) ? `SRS_TIME_W'(1) : fallTime;
   wire [`SRS_ACC_W-1:0]  targetAcc = {targetVout, `SRS_FRAC_W'(0)};
   wire [`SRS_ACC_W-1:0]  stepUp   = targetAcc / `SRS_ACC_W'(riseDiv);
   wire [`SRS_ACC_W-1:0]  stepDnCalc = acc_r / `SRS_ACC_W'(fallDiv);
   wire [`SRS_REF_W-1:0]  refNow   = acc_r[`SRS_ACC_W-1:`SRS_FRAC_W];
   wire                   errHigh  = (errorAdc > 8'sd0);
   wire                   errLow   = (errorAdc < 8'sd0);
   wire                   canRise  = (refNow != `SRS_REF_MAX);
   wire                   canFall  = (refNow != '0);
   wire [`SRS_ACC_W-1:0]  accUp    = canRise ? acc_r + `SRS_ACC_LSB : acc_r;
   wire [`SRS_ACC_W-1:0]  accDown  = canFall ? acc_r - `SRS_ACC_LSB : acc_r;
   // reference chases the output: high error means output sits above reference
   wire [`SRS_ACC_W-1:0]  accChase = errHigh ? accUp : (errLow ? accDown : acc_r);
   wire                   satOverride = errorAdcSat & pwmOutput;
   wire                   enableReady = (refNow >= prebias_r) && (duty > minPulse);
   wire                   riseLast = ({1'b0, cnt_r} + 17'd1) >= {1'b0, riseDiv};
   wire                   fallLast = (({1'b0, cnt_r} + 17'd1) >= {1'b0, fallDiv}) || (acc_r <= stepDn_r);
   wire [`SRS_ACC_W-1:0]  accRise  = ((targetAcc - acc_r) <= stepUp) ? targetAcc : acc_r + stepUp;
   wire [`SRS_TIME_W-1:0] cntInc   = cnt_r + `SRS_TIME_W'(1);

   always_comb begin
      state_nxt   = state_r;
      acc_nxt     = acc_r;
      cnt_nxt     = cnt_r;
      stepDn_nxt  = stepDn_r;
      prebias_nxt = prebias_r;
      pwm_nxt     = pwmOutput;
      sr_nxt      = syncRectifierEnable;
      tickRestart = 1'b0;
      unique case (state_r)
         soft_ramp_pkg::ST_IDLE: begin
            pwm_nxt = 1'b0;
            sr_nxt  = 1'b0;
            if (runReq) begin
               state_nxt   = soft_ramp_pkg::ST_ON_WAIT;
               cnt_nxt     = '0;
               tickRestart = 1'b1;
            end else if (tick) begin
               acc_nxt = accChase;
            end
         end
         soft_ramp_pkg::ST_ON_WAIT: begin
            if (!runReq) begin
               state_nxt = soft_ramp_pkg::ST_IDLE;
            end else if (cnt_r == turnOnDelay) begin
               state_nxt   = soft_ramp_pkg::ST_RAMP_UP;
               cnt_nxt     = '0;
               acc_nxt     = `SRS_ACC_RESET;
               prebias_nxt = voutSense;
            end else if (tick) begin
               cnt_nxt = cntInc;
            end
         end
         soft_ramp_pkg::ST_RAMP_UP: begin
            if (!runReq) begin
               state_nxt   = soft_ramp_pkg::ST_OFF_WAIT;
               cnt_nxt     = '0;
               tickRestart = 1'b1;
            end else begin
               if (enableReady) begin
                  pwm_nxt = 1'b1;
                  sr_nxt  = 1'b1;
               end
               if (tick) begin
                  if (satOverride) begin
                     acc_nxt = accChase;
                  end else if (riseLast) begin
                     acc_nxt   = targetAcc;
                     state_nxt = soft_ramp_pkg::ST_REGULATE;
                     pwm_nxt   = 1'b1;
                     sr_nxt    = 1'b1;
                  end else begin
                     acc_nxt = accRise;
                     cnt_nxt = cntInc;
                  end
               end
            end
         end
         soft_ramp_pkg::ST_REGULATE: begin
            acc_nxt = targetAcc;
            if (!runReq) begin
               state_nxt   = soft_ramp_pkg::ST_OFF_WAIT;
               cnt_nxt     = '0;
               tickRestart = 1'b1;
            end
         end
         soft_ramp_pkg::ST_OFF_WAIT: begin
            // a stop, once requested, runs to idle before a new start is taken
            if (cnt_r == turnOffDelay) begin
               state_nxt  = soft_ramp_pkg::ST_RAMP_DN;
               cnt_nxt    = '0;
               stepDn_nxt = stepDnCalc;
               sr_nxt     = syncRectifierEnable & soleSource;
            end else if (tick) begin
               cnt_nxt = cntInc;
            end
         end
         soft_ramp_pkg::ST_RAMP_DN: begin
            if (syncRectifierEnable && duty <= minPulse) begin
               sr_nxt = 1'b0;
            end
            if (tick) begin
               if (satOverride) begin
                  acc_nxt = accChase;
               end else if (fallLast) begin
                  acc_nxt   = `SRS_ACC_RESET;
                  state_nxt = soft_ramp_pkg::ST_IDLE;
                  pwm_nxt   = 1'b0;
                  sr_nxt    = 1'b0;
               end else begin
                  acc_nxt = acc_r - stepDn_r;
                  cnt_nxt = cntInc;
               end
            end
         end
         default: begin
            state_nxt = soft_ramp_pkg::ST_IDLE;
            pwm_nxt   = 1'b0;
            sr_nxt    = 1'b0;
         end
      endcase
   end

   // ramps and delays share the ramp bank; regulation picks by load
   always_comb begin
      if (state_nxt == soft_ramp_pkg::ST_REGULATE)
         mode_nxt = lightLoad ? soft_ramp_pkg::MODE_LIGHT : soft_ramp_pkg::MODE_NORMAL;
      else
         mode_nxt = soft_ramp_pkg::MODE_RAMP;
   end

   wire [`SRS_GAIN_W-1:0] gainSel = (mode_nxt == soft_ramp_pkg::MODE_LIGHT)  ? gainLight :
                                    (mode_nxt == soft_ramp_pkg::MODE_NORMAL) ? gainNormal : gainRamp;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_r   <= soft_ramp_pkg::ST_IDLE;
         acc_r     <= `SRS_ACC_RESET;
         stepDn_r  <= `SRS_ACC_RESET;
         cnt_r     <= '0;
         prebias_r <= '0;
      end else begin
         state_r   <= state_nxt;
         acc_r     <= acc_nxt;
         stepDn_r  <= stepDn_nxt;
         cnt_r     <= cnt_nxt;
         prebias_r <= prebias_nxt;
      end
   end

   // the compensator sees this reference and forms duty from its error
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pwmOutput           <= 1'b0;
         syncRectifierEnable <= 1'b0;
         opMode              <= soft_ramp_pkg::MODE_RAMP;
         loopGain            <= `SRS_GAIN_RESET;
      end else begin
         pwmOutput           <= pwm_nxt;
         syncRectifierEnable <= sr_nxt;
         opMode              <= mode_nxt;
         loopGain            <= gainSel;
      end
   end

   assign refDac    = refNow;
   assign railState = state_r;
   assign regulated = (state_r == soft_ramp_pkg::ST_REGULATE);

   idle_outputs_off_a: assert property (
      @(posedge clock) disable iff (rst)
      (state_r == soft_ramp_pkg::ST_IDLE) && $past(state_r == soft_ramp_pkg::ST_IDLE)
      |-> !pwmOutput && !syncRectifierEnable)
      else $error("outputs active while rail idle");

   enable_gate_a: assert property (
      @(posedge clock) disable iff (rst)
      $rose(pwmOutput) && $past(state_r == soft_ramp_pkg::ST_RAMP_UP) && $past(!tick)
      |-> $past(refNow >= prebias_r) && $past(duty > minPulse))
      else $error("outputs enabled before pre-bias and minimum pulse met");

   ramp_rate_a: assert property (
      @(posedge clock) disable iff (rst)
      $past(state_r == soft_ramp_pkg::ST_RAMP_UP) && (state_r == soft_ramp_pkg::ST_RAMP_UP)
      && (refDac != $past(refDac)) |-> $past(tick))
      else $error("reference moved off an update period");

   shared_sr_off_a: assert property (
      @(posedge clock) disable iff (rst)
      $rose(state_r == soft_ramp_pkg::ST_RAMP_DN) && !$past(soleSource) |-> !syncRectifierEnable)
      else $error("rectifier still on at start of shared-rail stop");

   final_clamp_a: assert property (
      @(posedge clock) disable iff (rst)
      $rose(regulated) |-> (refDac == $past(targetVout)) ##1 (refDac == $past(targetVout)))
      else $error("reference not at target when regulation reached");

   sat_override_a: assert property (
      @(posedge clock) disable iff (rst)
      (state_r == soft_ramp_pkg::ST_RAMP_UP) && runReq && tick && errorAdcSat && pwmOutput
      && (errorAdc > 8'sd0) && (refDac != `SRS_REF_MAX) |=> refDac == $past(refDac) + 12'h001)
      else $error("saturation did not step reference toward output");

   stop_to_idle_a: assert property (
      @(posedge clock) disable iff (rst)
      (state_r == soft_ramp_pkg::ST_RAMP_DN) && tick && !(errorAdcSat && pwmOutput) && fallLast
      |=> (state_r == soft_ramp_pkg::ST_IDLE) && !pwmOutput && (refDac == 12'h000))
      else $error("finished stop ramp did not return to idle");

   bank_select_a: assert property (
      @(posedge clock) disable iff (rst)
      (opMode == soft_ramp_pkg::MODE_RAMP) && !$past(rst) |-> (loopGain == $past(gainRamp)))
      else $error("ramp mode without ramp gain bank");

   idle_chase_a: assert property (
      @(posedge clock) disable iff (rst)
      (state_r == soft_ramp_pkg::ST_IDLE) && !runReq && tick && (errorAdc < 8'sd0)
      && (refDac != 12'h000) |=> refDac == $past(refDac) - 12'h001)
      else $error("idle reference did not follow error");

   on_delay_a: assert property (
      @(posedge clock) disable iff (rst)
      (state_r == soft_ramp_pkg::ST_ON_WAIT) && runReq && (cnt_r != turnOnDelay)
      |=> state_r != soft_ramp_pkg::ST_RAMP_UP)
      else $error("ramp began before turn-on delay elapsed");

   off_delay_a: assert property (
      @(posedge clock) disable iff (rst)
      $rose(state_r == soft_ramp_pkg::ST_RAMP_DN) |-> $past(cnt_r == turnOffDelay))
      else $error("stop ramp began before turn-off delay elapsed");

endmodule

// >>> verif/rail_model.sv
`timescale 1ns/10ps
`include "soft_ramp_regs.svh"

module rail_model #(
   parameter logic [`SRS_REF_W-1:0] VIN_CODE = 12'hfff
) (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst,
   // controls from the sequencer
   input  wire logic        [`SRS_REF_W-1:0] refDac,
   input  wire logic                         pwmOutput,
   // bench knobs: output level with stages off, forced saturation
   input  wire logic        [`SRS_REF_W-1:0] biasVal,
   input  wire logic                         satForce,
   // sensed rail
   output logic             [`SRS_REF_W-1:0] voutSense,
   output logic             [`SRS_REF_W-1:0] vinSense,
   output logic signed      [7:0]            errorAdc,
   output logic                              errorAdcSat
);
   logic signed [`SRS_REF_W:0] diffCode;

   // positive error means the output sits above the reference
   assign diffCode    = $signed({1'b0, voutSense}) - $signed({1'b0, refDac});
   assign errorAdc    = (diffCode > 127) ? 8'sh7f : ((diffCode < -128) ? 8'sh80 : diffCode[7:0]);
   assign errorAdcSat = satForce;
   assign vinSense    = VIN_CODE;

   // stages off: the rail sits at its pre-bias; stages on: the loop slews one code a clock
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         voutSense <= 12'h000;
      end else if (!pwmOutput) begin
         voutSense <= biasVal;
      end else if (satForce) begin
         // a load transient throws the output upward so the error really saturates
         voutSense <= (voutSense == `SRS_REF_MAX) ? voutSense : voutSense + 12'h001;
      end else if (voutSense < refDac) begin
         voutSense <= voutSense + 12'h001;
      end else if (voutSense > refDac) begin
         voutSense <= voutSense - 12'h001;
      end
   end
endmodule

// >>> verif/soft_ramp_sequencer_test.sv
`timescale 1ns/10ps
`include "soft_ramp_regs.svh"

module soft_ramp_sequencer_test;
   logic                           clock, rst;
   logic                           controlInputPin, pinControlEnable, cmdOn, cmdControlEnable;
   logic        [`SRS_TIME_W-1:0]  turnOnDelay, riseTime, turnOffDelay, fallTime;
   logic        [`SRS_REF_W-1:0]   targetVout, minPulse, voutSense, vinSense, refDac, biasVal, pwmRef, prevRef;
   logic                           soleSource, lightLoad, errorAdcSat, satForce, pwmSeen;
   logic                           pwmOutput, syncRectifierEnable, regulated;
   logic        [7:0]              prebiasScale;
   logic signed [`SRS_REF_W-1:0]   prebiasOffset;
   logic signed [7:0]              errorAdc;
   logic        [`SRS_GAIN_W-1:0]  gainRamp, gainNormal, gainLight, loopGain;
   soft_ramp_pkg::op_mode_t        opMode;
   soft_ramp_pkg::rail_state_t     railState;
   int                             miscompares, checked, n1, n2, n3;

   soft_ramp_sequencer dut_u (.clock(clock), .rst(rst), .controlInputPin(controlInputPin),
      .pinControlEnable(pinControlEnable), .cmdOn(cmdOn), .cmdControlEnable(cmdControlEnable),
      .turnOnDelay(turnOnDelay), .riseTime(riseTime), .turnOffDelay(turnOffDelay), .fallTime(fallTime),
      .targetVout(targetVout), .soleSource(soleSource), .minPulse(minPulse), .prebiasScale(prebiasScale),
      .prebiasOffset(prebiasOffset), .gainRamp(gainRamp), .gainNormal(gainNormal), .gainLight(gainLight),
      .lightLoad(lightLoad), .voutSense(voutSense), .vinSense(vinSense), .errorAdc(errorAdc),
      .errorAdcSat(errorAdcSat), .refDac(refDac), .pwmOutput(pwmOutput),
      .syncRectifierEnable(syncRectifierEnable), .loopGain(loopGain), .opMode(opMode),
      .railState(railState), .regulated(regulated));

   rail_model rail_u (.clock(clock), .rst(rst), .refDac(refDac), .pwmOutput(pwmOutput), .biasVal(biasVal),
      .satForce(satForce), .voutSense(voutSense), .vinSense(vinSense), .errorAdc(errorAdc),
      .errorAdcSat(errorAdcSat));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // reference code at the first edge the stages are seen on; re-arms while they are off
   always @(posedge clock) begin
      pwmSeen <= (pwmOutput === 1'b1);
      if (pwmOutput === 1'b1 && pwmSeen !== 1'b1)
         pwmRef <= refDac;
   end

   task automatic end_of_test();
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // inputs always move 10 ns after the rising edge
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
      #10;
   endtask

   task automatic wait_state(input soft_ramp_pkg::rail_state_t st, input int limit, output int n);
      n = 0;
      while (railState !== st) begin
         if (n >= limit) begin
            check("railState", railState, st);
            end_of_test();
         end
         cycles(1);
         n++;
      end
   endtask

   task automatic wait_ref(input int limit, output int n);
      logic [`SRS_REF_W-1:0] startRef;
      startRef = refDac;
      n = 0;
      while (refDac === startRef) begin
         if (n >= limit) begin
            check("refDac", refDac, startRef + 12'h001);
            end_of_test();
         end
         cycles(1);
         n++;
      end
   endtask

   initial begin
      miscompares = 0; checked = 0; rst = 1'b1;
      controlInputPin = 1'b0; pinControlEnable = 1'b0; cmdOn = 1'b0; cmdControlEnable = 1'b1;
      turnOnDelay = 16'h0002; riseTime = 16'h0004; turnOffDelay = 16'h0001; fallTime = 16'h0004;
      targetVout = 12'h400; minPulse = 12'h000; soleSource = 1'b0; lightLoad = 1'b0; satForce = 1'b0;
      prebiasScale = 8'h80; prebiasOffset = 12'sh000; biasVal = 12'h010;
      gainRamp = 16'h1111; gainNormal = 16'h2222; gainLight = 16'h3333;
      cycles(20);
      rst = 1'b0;
      check("railState", railState, soft_ramp_pkg::ST_IDLE);
      check("pwmOutput", pwmOutput, 1'b0);
      check("syncRectifierEnable", syncRectifierEnable, 1'b0);
      cycles(1);
      check("loopGain", loopGain, gainRamp);
      // idle trim: rail above reference, reference creeps up one code a tick
      wait_ref(1100, n1);
      check("refDac", refDac, 12'h001);
      biasVal = 12'h000;
      cycles(1100);
      // plain start from the host command
      cmdOn = 1'b1;
      cycles(1);
      check("railState", railState, soft_ramp_pkg::ST_ON_WAIT);
      wait_state(soft_ramp_pkg::ST_RAMP_UP, 2100, n1);
      wait_ref(1100, n2);
      check("refDac", refDac, 12'h100);
      check("opMode", opMode, soft_ramp_pkg::MODE_RAMP);
      check("loopGain", loopGain, gainRamp);
      // duty estimate is registered, so the enable follows the first step by two edges
      cycles(2);
      check("pwmOutput", pwmOutput, 1'b1);
      wait_state(soft_ramp_pkg::ST_REGULATE, 3100, n3);
      check("startTime", (3 + n1 + n2 + n3 >= 6000) && (3 + n1 + n2 + n3 <= 6003), 1'b1);
      check("refDac", refDac, targetVout);
      check("regulated", regulated, 1'b1);
      check("opMode", opMode, soft_ramp_pkg::MODE_NORMAL);
      check("loopGain", loopGain, gainNormal);
      lightLoad = 1'b1;
      cycles(2);
      check("opMode", opMode, soft_ramp_pkg::MODE_LIGHT);
      check("loopGain", loopGain, gainLight);
      lightLoad = 1'b0;
      // shared rail stop
      cmdOn = 1'b0;
      cycles(1);
      check("railState", railState, soft_ramp_pkg::ST_OFF_WAIT);
      wait_state(soft_ramp_pkg::ST_RAMP_DN, 1100, n1);
      check("offDelay", (n1 >= 990) && (n1 <= 1002), 1'b1);
      cycles(1);
      check("syncRectifierEnable", syncRectifierEnable, 1'b0);
      check("pwmOutput", pwmOutput, 1'b1);
      wait_state(soft_ramp_pkg::ST_IDLE, 4100, n1);
      check("fallTime", (n1 >= 2990) && (n1 <= 4002), 1'b1);
      check("pwmOutput", pwmOutput, 1'b0);
      check("syncRectifierEnable", syncRectifierEnable, 1'b0);
      check("refDac", refDac, 12'h000);
      // pre-bias start from the pin, minimum pulse above the pre-bias
      biasVal = 12'h200; minPulse = 12'h300; soleSource = 1'b1;
      cmdControlEnable = 1'b0; pinControlEnable = 1'b1;
      cycles(5);
      controlInputPin = 1'b1;
      wait_state(soft_ramp_pkg::ST_ON_WAIT, 5, n1);
      wait_state(soft_ramp_pkg::ST_REGULATE, 6100, n2);
      check("startTime", (n1 + n2 >= 5999) && (n1 + n2 <= 6005), 1'b1);
      cycles(2);
      check("enableAboveMin", pwmRef > minPulse, 1'b1);
      check("enableAboveBias", pwmRef >= biasVal, 1'b1);
      controlInputPin = 1'b0;
      wait_state(soft_ramp_pkg::ST_RAMP_DN, 1200, n1);
      cycles(1);
      check("syncRectifierEnable", syncRectifierEnable, 1'b1);
      // first down step lands on the minimum pulse duty: rectifier drops, stages stay on
      wait_ref(1100, n3);
      cycles(3);
      check("syncRectifierEnable", syncRectifierEnable, 1'b0);
      check("pwmOutput", pwmOutput, 1'b1);
      wait_state(soft_ramp_pkg::ST_IDLE, 4100, n1);
      // saturation in mid-ramp
      biasVal = 12'h000; minPulse = 12'h000; turnOnDelay = 16'h0001;
      cmdControlEnable = 1'b1; pinControlEnable = 1'b0;
      cycles(1100);
      cmdOn = 1'b1;
      wait_state(soft_ramp_pkg::ST_RAMP_UP, 1100, n1);
      wait_ref(1100, n2);
      satForce = 1'b1;
      prevRef = refDac;
      wait_ref(1100, n3);
      check("satStep", (refDac === prevRef + 12'h001) || (refDac === prevRef - 12'h001), 1'b1);
      satForce = 1'b0;
      prevRef = refDac;
      wait_ref(1100, n3);
      check("refDac", refDac, prevRef + 12'h100);
      wait_state(soft_ramp_pkg::ST_REGULATE, 3100, n3);
      check("refDac", refDac, targetVout);
      check("stretched", n3 > 1990, 1'b1);
      cmdOn = 1'b0;
      wait_state(soft_ramp_pkg::ST_IDLE, 6100, n1);
      end_of_test();
   end
endmodule
